/* sfec_ctrl.sv */
// serial flash erase, write-enable, status and parameter-table controller
`timescale 1ns/100ps
module sfec_ctrl
  import sfec_pkg::*;
#(
  parameter logic [31:0] BULK_CYC = ERASE_BULK_CYC,
  parameter logic [31:0] SECT_CYC = ERASE_SECT_CYC,
  parameter logic [31:0] SUB_CYC = ERASE_SUB_CYC
)(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // serial pins
  input wire logic chip_sel_n_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_io0_in,
  output logic serial_data_io1_out,
  output logic serial_data_io1_oe_out,
  // array erase port
  output logic erase_start_out,
  output logic [1:0] erase_kind_out,
  output logic [23:0] erase_addr_out,
  // status and power
  output logic wip_out,
  output logic wel_out,
  output logic standby_out
);
  logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3, d0_s1, d0_s2;
  logic sclk_rise, sclk_fall, cs_rise;
  logic [7:0] bit_cnt_reg, bit_cnt_next, opcode_reg, opcode_next;
  logic [31:0] shift_reg, shift_next, timer_reg, timer_next;
  logic wel_reg, wel_next, wip_reg, wip_next;
  logic start_reg, start_next, standby_reg, standby_next;
  logic [1:0] kind_reg, kind_next;
  logic [23:0] addr_reg, addr_next;
  logic [7:0] tx_byte_reg, tx_byte_next, pf_ptr_reg, pf_ptr_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic io1_reg, io1_next, oe_reg, oe_next, pf_on_reg, pf_on_next;
  logic tx_en, pop, fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data, load_byte;

  // read-only parameter table; unlisted bytes read as fill
  function automatic logic [7:0] table_byte(input logic [7:0] idx);
    unique case (idx)
      8'h00: table_byte = 8'h53;
      8'h01: table_byte = 8'h46;
      8'h02: table_byte = 8'h44;
      8'h03: table_byte = 8'h50;
      default: table_byte = TABLE_FILL;
    endcase
  endfunction

  // two-stage synchronisers; third stage only for edge finding
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {d0_s1, d0_s2} <= 2'h0;
    end
    else
    begin
      {sclk_s1, sclk_s2, sclk_s3} <= {serial_clock_in, sclk_s1, sclk_s2};
      {cs_s1, cs_s2, cs_s3} <= {chip_sel_n_in, cs_s1, cs_s2};
      {d0_s1, d0_s2} <= {serial_data_io0_in, d0_s1};
    end
  end

  assign sclk_rise = sclk_s2 && !sclk_s3;
  assign sclk_fall = !sclk_s2 && sclk_s3;
  assign cs_rise = cs_s2 && !cs_s3;
  sfec_fifo #(.WIDTH(TABLE_FIFO_WIDTH), .DEPTH(TABLE_FIFO_DEPTH))
  u_table_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .flush_in(cs_s2),
    .in_valid_in(pf_on_reg),
    .in_data_in(table_byte(pf_ptr_reg)),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(pop)
  );

  always_comb
  begin
    {bit_cnt_next, opcode_next, shift_next, timer_next} =
      {bit_cnt_reg, opcode_reg, shift_reg, timer_reg};
    {wel_next, wip_next, kind_next, addr_next} =
      {wel_reg, wip_reg, kind_reg, addr_reg};
    {tx_byte_next, tx_bit_next, io1_next, oe_next} =
      {tx_byte_reg, tx_bit_reg, io1_reg, oe_reg};
    {pf_ptr_next, pf_on_next} = {pf_ptr_reg, pf_on_reg};
    {start_next, pop} = 2'h0;
    load_byte = {6'h00, wel_reg, wip_reg};
    tx_en = (opcode_reg == OP_RD_STATUS && bit_cnt_reg >= OPCODE_BITS) ||
            (opcode_reg == OP_RD_TABLE && pf_on_reg &&
             bit_cnt_reg >= TABLE_FIRST_CLK);
    if (cs_s2)
    begin
      bit_cnt_next = '0;
      tx_bit_next = '0;
      oe_next = 1'b0;
      pf_on_next = 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        shift_next = {shift_reg[30:0], d0_s2};
        if (bit_cnt_reg != BIT_CNT_MAX)
          bit_cnt_next = bit_cnt_reg + 8'h01;
        if (bit_cnt_reg == OPCODE_BITS - 8'h01)
          opcode_next = {shift_reg[6:0], d0_s2};
        // table start byte from low address bits, skipped while busy
        if (bit_cnt_reg == ADDR_END_BITS - 8'h01 &&
            opcode_reg == OP_RD_TABLE && !wip_reg)
        begin
          pf_ptr_next = {shift_reg[6:0], d0_s2};
          pf_on_next = 1'b1;
        end
      end
      if (pf_on_reg && fifo_in_ready)
        pf_ptr_next = pf_ptr_reg + 8'h01;
      if (sclk_fall && tx_en)
      begin
        if (tx_bit_reg != 3'h0)
          load_byte = tx_byte_reg;
        else if (opcode_reg == OP_RD_TABLE)
        begin
          load_byte = fifo_out_data;
          pop = fifo_out_valid;
        end
        io1_next = load_byte[7];
        tx_byte_next = {load_byte[6:0], 1'b0};
        tx_bit_next = tx_bit_reg + 3'h1;
        oe_next = 1'b1;
      end
    end
    // self-timed erase countdown
    if (wip_reg)
    begin
      timer_next = timer_reg - 32'h0000_0001;
      if (timer_reg <= 32'h0000_0001)
        wip_next = 1'b0;
    end
    else if (cs_rise)
    begin
      unique case (opcode_reg)
        OP_WR_ENABLE, OP_WR_DISABLE:
          if (bit_cnt_reg == OPCODE_BITS)
            wel_next = (opcode_reg == OP_WR_ENABLE);
        OP_ERASE_BULK:
          if (bit_cnt_reg == OPCODE_BITS && wel_reg)
          begin
            kind_next = ERASE_BULK;
            addr_next = '0;
            timer_next = BULK_CYC;
            start_next = 1'b1;
          end
        OP_ERASE_SECT, OP_ERASE_SUB:
          if (bit_cnt_reg == ADDR_END_BITS && wel_reg)
          begin
            // any address inside the block selects it
            kind_next = (opcode_reg == OP_ERASE_SECT) ?
                        ERASE_SECT : ERASE_SUB;
            addr_next = shift_reg[23:0];
            timer_next = (opcode_reg == OP_ERASE_SECT) ?
                         SECT_CYC : SUB_CYC;
            start_next = 1'b1;
          end
        default:
          wel_next = wel_reg;
      endcase
      if (start_next)
      begin
        wip_next = 1'b1;
        wel_next = 1'b0;
      end
    end
    standby_next = cs_s2 && !wip_next;
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      {bit_cnt_reg, opcode_reg, shift_reg, timer_reg} <= '0;
      {wel_reg, wip_reg, start_reg, standby_reg} <= 4'h1;
      {kind_reg, addr_reg} <= {ERASE_NONE, 24'h00_0000};
      {tx_byte_reg, tx_bit_reg, io1_reg, oe_reg} <= '0;
      {pf_ptr_reg, pf_on_reg} <= '0;
    end
    else
    begin
      {bit_cnt_reg, opcode_reg, shift_reg, timer_reg} <=
        {bit_cnt_next, opcode_next, shift_next, timer_next};
      {wel_reg, wip_reg, start_reg, standby_reg} <=
        {wel_next, wip_next, start_next, standby_next};
      {kind_reg, addr_reg} <= {kind_next, addr_next};
      {tx_byte_reg, tx_bit_reg, io1_reg, oe_reg} <=
        {tx_byte_next, tx_bit_next, io1_next, oe_next};
      {pf_ptr_reg, pf_on_reg} <= {pf_ptr_next, pf_on_next};
    end
  end

  assign {serial_data_io1_out, serial_data_io1_oe_out} = {io1_reg, oe_reg};
  assign {erase_start_out, erase_kind_out} = {start_reg, kind_reg};
  assign erase_addr_out = addr_reg;
  assign {wip_out, wel_out, standby_out} = {wip_reg, wel_reg, standby_reg};
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_start_busy;
    start_reg |-> wip_reg && !wel_reg;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("erase start without busy bit");
  property p_wel_low_at_end;
    $fell(wip_reg) |-> !wel_reg;
  endproperty
  a_wel_low_at_end: assert property (p_wel_low_at_end)
    else $error("write latch still set at erase end");
  property p_start_needs_wel;
    start_reg |-> $past(wel_reg) && $past(cs_rise) && !$past(wip_reg);
  endproperty
  a_start_needs_wel: assert property (p_start_needs_wel)
    else $error("erase started without write latch");
  property p_bulk_on_rise;
    $past(cs_rise && opcode_reg == OP_ERASE_BULK && wel_reg && !wip_reg &&
      bit_cnt_reg == OPCODE_BITS) |-> start_reg && kind_reg == ERASE_BULK;
  endproperty
  a_bulk_on_rise: assert property (p_bulk_on_rise)
    else $error("bulk erase not started at select rise");
  property p_sect_on_rise;
    $past(cs_rise && opcode_reg == OP_ERASE_SECT && wel_reg && !wip_reg &&
      bit_cnt_reg == ADDR_END_BITS) |-> start_reg && kind_reg == ERASE_SECT &&
      addr_reg == $past(shift_reg[23:0]);
  endproperty
  a_sect_on_rise: assert property (p_sect_on_rise)
    else $error("sector erase not started at select rise");
  property p_sub_on_rise;
    $past(cs_rise && opcode_reg == OP_ERASE_SUB && wel_reg && !wip_reg &&
      bit_cnt_reg == ADDR_END_BITS) |-> start_reg && kind_reg == ERASE_SUB;
  endproperty
  a_sub_on_rise: assert property (p_sub_on_rise)
    else $error("subsector erase not started at select rise");
  property p_wren;
    cs_rise && opcode_reg == OP_WR_ENABLE && bit_cnt_reg == OPCODE_BITS &&
      !wip_reg |=> wel_reg;
  endproperty
  a_wren: assert property (p_wren)
    else $error("write enable did not set the latch");
  property p_table_first_bit;
    $rose(oe_reg) && opcode_reg == OP_RD_TABLE |->
      $past(bit_cnt_reg) == TABLE_FIRST_CLK && $past(sclk_fall);
  endproperty
  a_table_first_bit: assert property (p_table_first_bit)
    else $error("table data began on wrong clock");
  property p_count_on_rise;
    !cs_s2 && bit_cnt_reg != BIT_CNT_MAX && !sclk_rise |=>
      $stable(bit_cnt_reg);
  endproperty
  a_count_on_rise: assert property (p_count_on_rise)
    else $error("bit counted without serial clock rise");
  property p_power_mode;
    ##1 standby_reg == ($past(cs_s2) && !wip_reg);
  endproperty
  a_power_mode: assert property (p_power_mode)
    else $error("standby flag wrong");
  c_bulk: cover property (start_reg && kind_reg == ERASE_BULK);
  c_sect: cover property (start_reg && kind_reg == ERASE_SECT);
  c_sub: cover property (start_reg && kind_reg == ERASE_SUB);
  c_table: cover property ($rose(oe_reg) && opcode_reg == OP_RD_TABLE);
endmodule

/* sfec_pkg.sv */
// constants shared by the flash erase and parameter-table controller
package sfec_pkg;
  // system clock
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  // command opcodes
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_ERASE_BULK = 8'hC7;
  localparam logic [7:0] OP_ERASE_SECT = 8'hD8;
  localparam logic [7:0] OP_ERASE_SUB = 8'h20;
  localparam logic [7:0] OP_RD_TABLE = 8'h5A;
  // serial clock counts within one frame
  localparam logic [7:0] OPCODE_BITS = 8'h08;
  localparam logic [7:0] ADDR_END_BITS = 8'h20;
  localparam logic [7:0] TABLE_FIRST_CLK = 8'h28;
  localparam logic [7:0] BIT_CNT_MAX = 8'hFF;
  // erase kinds on the array port
  localparam logic [1:0] ERASE_NONE = 2'h0;
  localparam logic [1:0] ERASE_BULK = 2'h1;
  localparam logic [1:0] ERASE_SECT = 2'h2;
  localparam logic [1:0] ERASE_SUB = 2'h3;
  // status byte layout
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  // self-timed erase cycle times in ms
  localparam longint unsigned T_ERASE_BULK_MS = 64'd25000;
  localparam longint unsigned T_ERASE_SECT_MS = 64'd2000;
  localparam longint unsigned T_ERASE_SUB_MS = 64'd400;
  localparam logic [31:0] ERASE_BULK_CYC =
    32'(T_ERASE_BULK_MS * CLK_HZ / 64'd1000);
  localparam logic [31:0] ERASE_SECT_CYC =
    32'(T_ERASE_SECT_MS * CLK_HZ / 64'd1000);
  localparam logic [31:0] ERASE_SUB_CYC =
    32'(T_ERASE_SUB_MS * CLK_HZ / 64'd1000);
  // parameter-table buffer
  localparam int TABLE_FIFO_WIDTH = 8;
  localparam int TABLE_FIFO_DEPTH = 16;
  localparam logic [7:0] TABLE_FILL = 8'hFF;
endpackage

/* sfec_fifo.sv */
// synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/100ps
module sfec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  always_comb
  begin
    in_ready_out = (cnt_reg != (AW+1)'(DEPTH)) && !flush_in;
    out_valid_out = (cnt_reg != '0) && !flush_in;
    out_data_out = mem_reg[rd_reg];
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    wr_next = push ? wr_reg + AW'(1) : wr_reg;
    rd_next = pop ? rd_reg + AW'(1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_in)
    begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data_in;
  end
endmodule

/* sfec_host_model.sv */
// host-side serial master model that frames commands into the controller
`timescale 1ns/100ps
module sfec_host_model (
  // clock
  input wire logic clk_sys_in,
  // serial pins toward the device
  output logic chip_sel_n_out,
  output logic serial_clock_out,
  output logic serial_data_io0_out,
  input wire logic serial_data_io1_in,
  input wire logic serial_data_io1_oe_in
);
  // half period of the 80 ns serial clock in system cycles
  localparam int HALF = 4;

  initial
  begin
    chip_sel_n_out = 1'b1;
    serial_clock_out = 1'b0;
    serial_data_io0_out = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // n_in bits out msb first, then n_rd bits in; clock still outside frames
  task automatic frame(input logic [39:0] tx, input int n_in,
                       input int n_rd, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_sys_in);
    chip_sel_n_out <= 1'b0;
    idle(2);
    for (int k = 0; k < n_in + n_rd; k++)
    begin
      if (k < n_in)
        serial_data_io0_out <= tx[n_in-1-k];
      else
        serial_data_io0_out <= ~serial_data_io0_out;
      idle(HALF);
      serial_clock_out <= 1'b1;
      @(negedge clk_sys_in);
      // an undriven data line must not pass for a valid bit
      if (k >= n_in)
        rx = {rx[14:0], serial_data_io1_oe_in ? serial_data_io1_in : 1'bx};
      idle(HALF);
      serial_clock_out <= 1'b0;
    end
    idle(2);
    serial_data_io0_out <= ~serial_data_io0_out;
    chip_sel_n_out <= 1'b1;
    idle(8);
  endtask
endmodule

/* sfec_ctrl_tb.sv */
// self-checking testbench for the flash erase and parameter-table controller
`timescale 1ns/100ps
module sfec_ctrl_tb;
  import sfec_pkg::*;
  // shortened erase times for simulation
  localparam logic [31:0] BULK_T = 32'h0000_0190;
  localparam logic [31:0] SECT_T = 32'h0000_012C;
  localparam logic [31:0] SUB_T = 32'h0000_00C8;

  logic clk_sys_in, rst_n_in, chip_sel_n, serial_clock, io0, io1, io1_oe;
  logic erase_start, wip, wel, standby, cap_wel, cap_wip;
  logic [1:0] erase_kind, cap_kind;
  logic [23:0] erase_addr, cap_addr;
  logic [15:0] rx;
  int n_mismatch, comparisons, n_starts, wip_run;

  sfec_ctrl #(.BULK_CYC(BULK_T), .SECT_CYC(SECT_T), .SUB_CYC(SUB_T)) dut (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .chip_sel_n_in(chip_sel_n),
    .serial_clock_in(serial_clock),
    .serial_data_io0_in(io0),
    .serial_data_io1_out(io1),
    .serial_data_io1_oe_out(io1_oe),
    .erase_start_out(erase_start),
    .erase_kind_out(erase_kind),
    .erase_addr_out(erase_addr),
    .wip_out(wip),
    .wel_out(wel),
    .standby_out(standby)
  );

  sfec_host_model host (
    .clk_sys_in(clk_sys_in),
    .chip_sel_n_out(chip_sel_n),
    .serial_clock_out(serial_clock),
    .serial_data_io0_out(io0),
    .serial_data_io1_in(io1),
    .serial_data_io1_oe_in(io1_oe)
  );

  initial clk_sys_in = 1'b0;
  always #5 clk_sys_in = ~clk_sys_in;

  // captures the erase request and counts busy cycles from its start
  always @(negedge clk_sys_in)
  begin
    if (erase_start === 1'b1)
    begin
      n_starts++;
      cap_kind = erase_kind;
      cap_addr = erase_addr;
      cap_wel = wel;
      cap_wip = wip;
      wip_run = 1;
    end
    else if (wip === 1'b1)
      wip_run++;
  end

  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_reset;
    check("wip", wip, 24'h0);
    check("wel", wel, 24'h0);
    check("standby", standby, 24'h1);
    check("io1 enable", io1_oe, 24'h0);
    check("erase start", erase_start, 24'h0);
    check("erase kind", erase_kind, 24'(ERASE_NONE));
  endtask

  // erase without the write latch leaves the array alone
  task automatic t_no_wel;
    int s0;
    s0 = n_starts;
    host.frame(40'({OP_ERASE_SECT, 24'h00_1000}), 32, 0, rx);
    host.frame(40'(OP_ERASE_BULK), 8, 0, rx);
    // latch set then cleared again: the erase after it must be ignored
    host.frame(40'(OP_WR_ENABLE), 8, 0, rx);
    check("wel before disable", wel, 24'h1);
    host.frame(40'(OP_WR_DISABLE), 8, 0, rx);
    check("wel after disable", wel, 24'h0);
    host.frame(40'({OP_ERASE_SUB, 24'h00_2000}), 32, 0, rx);
    check("starts without latch", 24'(n_starts - s0), 24'h0);
    check("wip without latch", wip, 24'h0);
  endtask

  task automatic t_erase(input logic [7:0] op, input int n_in,
                         input logic [23:0] addr, input logic [1:0] kind,
                         input logic [31:0] cyc);
    int s0;
    host.frame(40'(OP_WR_ENABLE), 8, 0, rx);
    check("wel after enable", wel, 24'h1);
    s0 = n_starts;
    host.frame((n_in == 8) ? 40'(op) : 40'({op, addr}), n_in, 0, rx);
    check("erase starts", 24'(n_starts - s0), 24'h1);
    check("erase kind", cap_kind, 24'(kind));
    check("erase addr", cap_addr, addr);
    check("wel at start", cap_wel, 24'h0);
    check("wip at start", cap_wip, 24'h1);
    check("standby busy", standby, 24'h0);
    host.frame(40'(OP_RD_STATUS), 8, 8, rx);
    check("status busy", rx[7:0], 24'h01);
    // testbench waits on the wip output for up to 2000 cycles before further access
    for (int i = 0; i < 2000 && wip !== 1'b0; i++)
      @(negedge clk_sys_in);
    if (wip !== 1'b0)
    begin
      n_mismatch++;
      final_report();
    end
    check("busy length", 24'(wip_run), cyc[23:0]);
    @(negedge clk_sys_in);
    check("standby idle", standby, 24'h1);
  endtask

  task automatic t_table(input logic [7:0] addr, input logic [15:0] exp);
    host.frame({OP_RD_TABLE, 16'h0000, addr, 8'h00}, 40, 16, rx);
    check("table data", rx, 24'(exp));
    check("io1 released", io1_oe, 24'h0);
  endtask

  initial
  begin
    rst_n_in = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    n_starts = 0;
    wip_run = 0;
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_reset();
    t_no_wel();
    t_erase(OP_ERASE_BULK, 8, 24'h00_0000, ERASE_BULK, BULK_T);
    t_erase(OP_ERASE_SECT, 32, 24'h12_3456, ERASE_SECT, SECT_T);
    t_erase(OP_ERASE_SUB, 32, 24'hAB_CDEF, ERASE_SUB, SUB_T);
    t_table(8'h02, 16'h4450);
    t_table(8'hFF, 16'hFF53);
    final_report();
  end
endmodule
